// ### rtl/lsdi_defines.vh
/*
 Constants for the level switch discrete input block: register offsets,
 reset values, failsafe codes, status codes and timing counts.
 Assumes a 25 MHz clock and a 32-bit Avalon-MM slave with byte addresses.
*/
`ifndef LSDI_DEFINES_VH
`define LSDI_DEFINES_VH

// Register byte offsets
`define LSDI_REG_CTRL 6'h00
`define LSDI_REG_RANGE_LO 6'h04
`define LSDI_REG_RANGE_HI 6'h08
`define LSDI_REG_SWITCH 6'h0C
`define LSDI_REG_DELAY 6'h10
`define LSDI_REG_STATUS 6'h14
`define LSDI_REG_IRQ_STAT 6'h18
`define LSDI_REG_IRQ_MASK 6'h1C
`define LSDI_REG_LEVEL 6'h20

// Reset values and limits
`define LSDI_RST_RANGE_LO 16'h1652
`define LSDI_RST_RANGE_HI 16'hD055
`define LSDI_RST_SP_ON 7'h4B
`define LSDI_RST_SP_OFF 7'h19
`define LSDI_RST_DELAY 10'h000
`define LSDI_MAX_DELAY 10'h3E8
`define LSDI_PCT_FULL 7'h64

// Failsafe policies
`define LSDI_FS_DEFAULT 2'h0
`define LSDI_FS_HOLD 2'h1
`define LSDI_FS_PASS 2'h2
// Only unused selector code; writes of it are refused
`define LSDI_FS_INVALID 2'h3

// Status codes (quality byte)
`define LSDI_ST_GOOD 8'h80
`define LSDI_ST_SAFETY 8'h4B
`define LSDI_ST_HOLD 8'h47

// Tenth-of-second tick: 100 ms at 25 MHz
`define LSDI_TICK_MS 32'h0000_0064
`define LSDI_CLK_KHZ 32'h0000_61A8
`define LSDI_TICK_CYCLES (`LSDI_TICK_MS * `LSDI_CLK_KHZ)

// Quality bits: top two bits zero means bad
`define LSDI_QUAL_BAD 2'h0

`endif

// ### rtl/lsdi_scale.v
/*
 Level scaler: turns a raw count into a 0..100 percentage between two
 range counts, saturating outside the span. Registered result.
 Assumes range_hi above range_lo; otherwise the output sticks at 0.
*/
`include "lsdi_defines.vh"

module lsdi_scale
(
  input wire clk_i,
  input wire reset_n_i,
  input wire [15:0] raw_i,
  input wire [15:0] range_lo_i,
  input wire [15:0] range_hi_i,
  output reg [6:0] pct_o
);

  reg [16:0] span;
  reg [16:0] offs;
  reg [23:0] prod;
  reg [23:0] quot;
  reg [6:0] next_pct;

  // Linear map, clamped at both ends; divide is slow but cycle count is irrelevant here
  always @*
  begin
    span = {1'b0, range_hi_i} - {1'b0, range_lo_i};
    offs = {1'b0, raw_i} - {1'b0, range_lo_i};
    prod = offs[16:0] * `LSDI_PCT_FULL;
    quot = 24'h00_0000;
    if (raw_i <= range_lo_i || range_hi_i <= range_lo_i)
      next_pct = 7'h00;
    else if (raw_i >= range_hi_i)
      next_pct = `LSDI_PCT_FULL;
    else
    begin
      quot = prod / {7'h00, span};
      next_pct = quot[6:0];
    end
  end

  // Register the percentage
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      pct_o <= 7'h00;
    else
      pct_o <= next_pct;
  end

endmodule // lsdi_scale

// ### rtl/lsdi_delay.v
/*
 Delay timer: counts a programmed number of tenth-second ticks.
 Reloads whenever restart_i is high; done_o rises when the count ends.
 Assumes tick_i is a one-cycle pulse every 100 ms.
*/
module lsdi_delay
(
  input wire clk_i,
  input wire reset_n_i,
  input wire tick_i,
  input wire restart_i,
  input wire run_i,
  input wire [9:0] load_i,
  output reg done_o
);

  reg [9:0] count;

  // Reload on restart, count down on ticks while running
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      count <= 10'h000;
      done_o <= 1'b0;
    end
    else if (restart_i)
    begin
      count <= load_i;
      done_o <= 1'b0;
    end
    else if (run_i && !done_o)
    begin
      if (count == 10'h000)
        done_o <= 1'b1;
      else if (tick_i)
        count <= count - 10'h001;
    end
  end

endmodule // lsdi_delay

// ### rtl/lsdi_top.v
/*
 Level switch discrete input path: scaling, hysteresis switch, cover and
 uncover delays, inversion, failsafe policy, interrupt and Avalon-MM slave.
 Assumes raw count and quality arrive synchronous to clk_i, one per cycle.
*/
// Added by the designer: the Avalon-MM register port and the address map.

// Contract
// - Lower range count is the 0% point, left end of the bar graph.
// - Upper range count is the 100% point, right end of the bar graph.
// - Switch turns on when level reaches switch point one, default 75.
// - Switch turns off when level falls to switch point two, default 25.
// - Switch points are percentages and compared as percentages.
// - Each delay accepts 0 to 100 seconds in tenths.
// - Primary value asserts only after cover delay elapses.
// - Primary value deasserts only after independent uncover delay elapses.
// - Reverting sensor state before expiry reloads and restarts the timer.
// - Inversion on outputs the complement of the level status.
// - Bad input quality applies the selected failsafe policy.
// - Default policy outputs safety value with status U_075.
// - Hold policy outputs last valid value with status U_071.
// - Pass policy outputs the bad value with the incoming bad status.

`include "lsdi_defines.vh"

module lsdi_top
(
  input wire clk_i,
  input wire reset_n_i,
  input wire [15:0] raw_i,
  input wire [7:0] quality_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  output reg [6:0] level_pct_o,
  output reg primary_o,
  output reg [7:0] primary_status_o,
  output reg irq_o
);

  // Configuration
  reg [15:0] range_lo;
  reg [15:0] range_hi;
  reg [6:0] sp_on;
  reg [6:0] sp_off;
  reg [9:0] cover_delay;
  reg [9:0] uncover_delay;
  reg invert;
  reg [1:0] fs_mode;
  reg [7:0] safety_value;
  reg fs_reject;
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;

  // Datapath state
  wire [6:0] pct;
  reg switch_state;
  reg covered;
  reg pv_level;
  reg last_valid;
  reg [31:0] tick_cnt;
  reg tick;
  reg bad_d;
  wire cover_done;
  wire uncover_done;
  wire bad;
  reg busy;

  // Bus side helpers and interrupt sources
  wire [31:0] lo_merged;
  wire ev_fall;
  wire ev_rise;
  wire ev_bad;
  wire ev_reject;
  wire [3:0] irq_clear;

  // Byte-lane merge, used only for the lower range register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge = {be[3] ? wd[31:24] : old[31:24], be[2] ? wd[23:16] : old[23:16],
               be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Clamp a delay to the 100.0 s ceiling
  function [9:0] clamp_delay;
    input [15:0] v;
    begin
      if (v > {6'h00, `LSDI_MAX_DELAY})
        clamp_delay = `LSDI_MAX_DELAY;
      else
        clamp_delay = v[9:0];
    end
  endfunction

  assign bad = (quality_i[7:6] == `LSDI_QUAL_BAD);

  // Lower range word with byte lanes applied; only the low half is kept
  assign lo_merged = merge({16'h0000, range_lo}, avs_writedata_i, avs_byteenable_i);

  // Event terms match the moments the primary level actually moves
  assign ev_fall = !covered && !switch_state && uncover_done && pv_level;
  assign ev_rise = covered && switch_state && cover_done && !pv_level;
  assign ev_bad = bad && !bad_d;
  assign ev_reject = avs_write_i && !busy && avs_address_i == `LSDI_REG_CTRL &&
                     avs_byteenable_i[0] && avs_writedata_i[2:1] == `LSDI_FS_INVALID;
  // Write-one-to-clear mask, only on the cycle the write is taken
  assign irq_clear = (avs_write_i && !busy && avs_address_i == `LSDI_REG_IRQ_STAT) ?
                     avs_writedata_i[3:0] : 4'h0;

  lsdi_scale u_scale
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .raw_i(raw_i),
    .range_lo_i(range_lo),
    .range_hi_i(range_hi),
    .pct_o(pct)
  );

  // Tenth-second tick for the delay timers
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (tick_cnt == `LSDI_TICK_CYCLES - 32'h0000_0001)
    begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      switch_state <= 1'b0;
    else if (!switch_state && pct >= sp_on)
      switch_state <= 1'b1;
    else if (switch_state && pct <= sp_off)
      switch_state <= 1'b0;
  end

  // Sensor covered flag follows the switch, one cycle late for timer restart
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      covered <= 1'b0;
    else
      covered <= switch_state;
  end

  // cover delay restarts on every change of the switch
  lsdi_delay u_cover
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick),
    .restart_i(switch_state != covered),
    .run_i(switch_state),
    .load_i(cover_delay),
    .done_o(cover_done)
  );

  lsdi_delay u_uncover
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick),
    .restart_i(switch_state != covered),
    .run_i(!switch_state),
    .load_i(uncover_delay),
    .done_o(uncover_done)
  );

  // primary level moves only when its timer has elapsed
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      pv_level <= 1'b0;
    else if (covered && switch_state && cover_done)
      pv_level <= 1'b1;
    else if (!covered && !switch_state && uncover_done)
      pv_level <= 1'b0;
  end

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      primary_o <= 1'b0;
      primary_status_o <= `LSDI_ST_GOOD;
      last_valid <= 1'b0;
      level_pct_o <= 7'h00;
    end
    else
    begin
      level_pct_o <= pct;
      if (!bad)
      begin
        primary_o <= pv_level ^ invert;
        last_valid <= pv_level ^ invert;
        primary_status_o <= `LSDI_ST_GOOD;
      end
      else
      begin
        case (fs_mode)
          `LSDI_FS_DEFAULT:
          begin
            primary_o <= safety_value[0];
            primary_status_o <= `LSDI_ST_SAFETY;
          end
          `LSDI_FS_HOLD:
          begin
            primary_o <= last_valid;
            primary_status_o <= `LSDI_ST_HOLD;
          end
          default:
          begin
            primary_o <= pv_level ^ invert;
            primary_status_o <= quality_i;
          end
        endcase
      end
    end
  end

  // Event edge detect on input quality
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      bad_d <= 1'b0;
    else
      bad_d <= bad;
  end

  // Register slave: one wait state, then answer; interrupt bits set beats clear
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      range_lo <= `LSDI_RST_RANGE_LO;
      range_hi <= `LSDI_RST_RANGE_HI;
      sp_on <= `LSDI_RST_SP_ON;
      sp_off <= `LSDI_RST_SP_OFF;
      cover_delay <= `LSDI_RST_DELAY;
      uncover_delay <= `LSDI_RST_DELAY;
      invert <= 1'b0;
      fs_mode <= `LSDI_FS_DEFAULT;
      safety_value <= 8'h00;
      fs_reject <= 1'b0;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      avs_readdata_o <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
      busy <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_stat & irq_mask);
      avs_waitrequest_o <= 1'b1;
      busy <= 1'b0;
      if ((avs_read_i || avs_write_i) && !busy)
      begin
        busy <= 1'b1;
        avs_waitrequest_o <= 1'b0;
        if (avs_read_i)
        begin
          case (avs_address_i)
            `LSDI_REG_CTRL: avs_readdata_o <= {16'h0000, safety_value, 4'h0,
                                               fs_reject, fs_mode, invert};
            `LSDI_REG_RANGE_LO: avs_readdata_o <= {16'h0000, range_lo};
            `LSDI_REG_RANGE_HI: avs_readdata_o <= {16'h0000, range_hi};
            `LSDI_REG_SWITCH: avs_readdata_o <= {9'h000, sp_off, 9'h000, sp_on};
            `LSDI_REG_DELAY: avs_readdata_o <= {6'h00, uncover_delay, 6'h00, cover_delay};
            `LSDI_REG_STATUS: avs_readdata_o <= {16'h0000, primary_status_o, 4'h0,
                                                 bad, pv_level, switch_state, primary_o};
            `LSDI_REG_IRQ_STAT: avs_readdata_o <= {28'h000_0000, irq_stat};
            `LSDI_REG_IRQ_MASK: avs_readdata_o <= {28'h000_0000, irq_mask};
            `LSDI_REG_LEVEL: avs_readdata_o <= {25'h000_0000, pct};
            default: avs_readdata_o <= 32'h0000_0000;
          endcase
        end
        else
        begin
          case (avs_address_i)
            `LSDI_REG_CTRL:
            begin
              invert <= avs_byteenable_i[0] ? avs_writedata_i[0] : invert;
              // reject undefined policy codes, keep previous
              if (avs_byteenable_i[0])
              begin
                if (avs_writedata_i[2:1] == `LSDI_FS_INVALID)
                  fs_reject <= 1'b1;
                else
                begin
                  fs_mode <= avs_writedata_i[2:1];
                  fs_reject <= 1'b0;
                end
              end
              if (avs_byteenable_i[1])
                safety_value <= avs_writedata_i[15:8];
            end
            `LSDI_REG_RANGE_LO: range_lo <= lo_merged[15:0];
            `LSDI_REG_RANGE_HI: range_hi <= avs_writedata_i[15:0];
            `LSDI_REG_SWITCH:
            begin
              if (avs_writedata_i[6:0] <= `LSDI_PCT_FULL)
                sp_on <= avs_writedata_i[6:0];
              if (avs_writedata_i[22:16] <= `LSDI_PCT_FULL)
                sp_off <= avs_writedata_i[22:16];
            end
            // delays in tenths, clamped to 100.0 s
            `LSDI_REG_DELAY:
            begin
              cover_delay <= clamp_delay(avs_writedata_i[15:0]);
              uncover_delay <= clamp_delay(avs_writedata_i[31:16]);
            end
            `LSDI_REG_IRQ_MASK: irq_mask <= avs_writedata_i[3:0];
            default: ;
          endcase
        end
      end
      // Sticky events: primary rise, fall, quality goes bad, policy rejected
      // Set is ORed after the clear so a same-cycle event is never lost
      irq_stat <= (irq_stat & ~irq_clear) | {ev_reject, ev_bad, ev_rise, ev_fall};
    end
  end

endmodule // lsdi_top

// ### test/lsdi_checker.sv
/*
 Port checker for lsdi_top: bus answer timing, level range, status code
 and reset values. Assumes one clock and the bind in the bench top file.
*/
module lsdi_checker
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] raw_i,
  input wire logic [7:0] quality_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [6:0] level_pct_o,
  input wire logic primary_o,
  input wire logic [7:0] primary_status_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Bus answer lasts one cycle and only follows a request
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  wait_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("waitrequest low without a request");
  answer_time_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("request not answered in the next cycle");
  // Read data only move after a read was taken
  rd_hold_a: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data changed without a read");
  pct_max_a: assert property (level_pct_o <= 7'h64)
    else $error("level percentage above full scale");
  reset_vals_a: assert property ($rose(reset_n_i) |-> avs_waitrequest_o && !primary_o
    && !irq_o && avs_readdata_o == 32'h0000_0000 && primary_status_o == 8'h80
    && level_pct_o == 7'h00)
    else $error("outputs not at reset values");
  good_st_a: assert property ((quality_i[7:6] != 2'h0) [*4]
    |-> primary_status_o == 8'h80)
    else $error("good input without good status");
  bad_st_a: assert property ((quality_i[7:6] == 2'h0) [*4]
    |-> primary_status_o inside {8'h4B, 8'h47, quality_i})
    else $error("bad input without a failsafe status");
endmodule // lsdi_checker

// ### test/lsdi_reader.sv
/*
 Cyclic reader of the primary value, standing in for the bus master.
 Assumes it samples on the same clock as the block.
*/
module lsdi_reader
(
  input wire logic clk_i,
  input wire logic primary_i,
  output logic pv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One read per clock; the bench sees the value one cycle late
  always @(posedge clk_i)
  begin
    pv_o <= primary_i;
  end
endmodule // lsdi_reader

// ### test/tb.sv
/*
 Bench for lsdi_top: register reads and writes over Avalon-MM, level,
 switch, inversion, failsafe and interrupt checks through a result queue.
 Assumes delays stay at 0, since the tenth-second tick cannot be shortened.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic [15:0] raw_i = 16'h0000;
  logic [7:0] quality_i = 8'h80;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 0;
  logic avs_write_i = 0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hF;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o;
  wire [6:0] level_pct_o;
  wire primary_o;
  wire [7:0] primary_status_o;
  wire irq_o;
  wire pv;
  int err_count = 0;
  int compares = 0;
  int i;
  logic [15:0] r;
  logic [33:0] m;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  logic [33:0] msk_q[$];

  always #20 clk_i = ~clk_i;

  lsdi_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .raw_i(raw_i), .quality_i(quality_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .level_pct_o(level_pct_o), .primary_o(primary_o),
    .primary_status_o(primary_status_o), .irq_o(irq_o));
  lsdi_reader rdr (.clk_i(clk_i), .primary_i(primary_o), .pv_o(pv));

  task complete_run;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task check(input logic [33:0] seen, input logic [33:0] want);
    compares++;
    if (seen !== want)
    begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // One bus access; request held until waitrequest is sampled low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    // No cycle limit here: only the watchdog may end a stuck access
    while (avs_waitrequest_o !== 1'b0)
    begin
      @(posedge clk_i);
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task rd(input logic [5:0] a, input logic [33:0] e, input logic [33:0] k);
    exp_q.push_back(e & k);
    msk_q.push_back(k);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // Apply a raw count and let the pipeline settle
  task lvl(input logic [15:0] v);
    @(posedge clk_i);
    raw_i <= v;
    repeat (8) @(posedge clk_i);
  endtask

  task st(input logic sw, input logic p, input logic [7:0] q);
    rd(6'h14, {1'b0, p, 16'h0000, q, 6'h00, sw, p}, 34'h1_0000_FF03);
  endtask

  // Oldest note is compared when read data arrive; also irq and primary
  always @(posedge clk_i)
  begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
    begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      check({irq_o, pv, avs_readdata_o} & m, e);
      // Level port must agree with the level register once settled
      if (avs_address_i == 6'h20)
        check({27'h000_0000, level_pct_o}, e);
    end
  end

  // Watchdog sized well above the few hundred cycles of the tests
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run;
  end

  initial
  begin
    void'($urandom(32'hd0a8137a));
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(6'h04, 34'h0_0000_1652, 34'h0_0000_FFFF);
    rd(6'h08, 34'h0_0000_D055, 34'h0_0000_FFFF);
    rd(6'h0C, 34'h0_0019_004B, 34'h0_007F_007F);
    rd(6'h10, 34'h0_0000_0000, 34'h0_03FF_03FF);
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
    rd(6'h3C, 34'h0_0000_0000, 34'h0_FFFF_FFFF);
    $display("register test done");
    // Narrow span so the percentage equals raw minus 1000
    bus(1'b1, 6'h04, 32'h0000_03E8);
    bus(1'b1, 6'h08, 32'h0000_044C);
    lvl(16'h0100);
    rd(6'h20, 34'h0_0000_0000, 34'h0_0000_007F);
    lvl(16'hF000);
    rd(6'h20, 34'h0_0000_0064, 34'h0_0000_007F);
    lvl(16'h03E8);
    rd(6'h20, 34'h0_0000_0000, 34'h0_0000_007F);
    lvl(16'h044C);
    rd(6'h20, 34'h0_0000_0064, 34'h0_0000_007F);
    for (i = 0; i < 4; i++)
    begin
      r = 16'h03E8 + 16'($urandom_range(100));
      lvl(r);
      rd(6'h20, {18'h0_0000, r - 16'h03E8}, 34'h0_0000_007F);
    end
    $display("scaling test done");
    lvl(16'h0438);
    st(1'b1, 1'b1, 8'h80);
    lvl(16'h041A);
    st(1'b1, 1'b1, 8'h80);
    lvl(16'h0401);
    st(1'b0, 1'b0, 8'h80);
    lvl(16'h041A);
    st(1'b0, 1'b0, 8'h80);
    lvl(16'h0433);
    st(1'b1, 1'b1, 8'h80);
    bus(1'b1, 6'h00, 32'h0000_0001);
    lvl(16'h0433);
    st(1'b1, 1'b0, 8'h80);
    bus(1'b1, 6'h00, 32'h0000_0000);
    $display("switch test done");
    lvl(16'h03E8);
    // Each policy in turn, safety value 1 against a switch that is off
    for (i = 0; i < 3; i++)
    begin
      bus(1'b1, 6'h00, {16'h0000, 8'h01, 5'h00, 2'(i), 1'b0});
      quality_i <= 8'h10;
      lvl(16'h03E8);
      case (i)
        0: st(1'b0, 1'b1, 8'h4B);
        1: st(1'b0, 1'b0, 8'h47);
        default: rd(6'h14, 34'h0_0000_1000, 34'h0_0000_FF00);
      endcase
      quality_i <= 8'h80;
      lvl(16'h03E8);
    end
    bus(1'b1, 6'h00, 32'h0000_0106);
    rd(6'h00, 34'h0_0000_000C, 34'h0_0000_000E);
    rd(6'h18, 34'h0_0000_0008, 34'h2_0000_0008);
    bus(1'b1, 6'h1C, 32'h0000_0008);
    lvl(16'h03E8);
    rd(6'h18, 34'h2_0000_0008, 34'h2_0000_0008);
    bus(1'b1, 6'h18, 32'h0000_0008);
    lvl(16'h03E8);
    rd(6'h18, 34'h0_0000_0000, 34'h2_0000_0008);
    bus(1'b1, 6'h10, 32'h03FF_03FF);
    rd(6'h10, 34'h0_03E8_03E8, 34'h0_03FF_03FF);
    bus(1'b1, 6'h10, 32'h0000_0000);
    $display("failsafe test done");
    complete_run;
  end
endmodule // tb

bind lsdi_top lsdi_checker chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .raw_i(raw_i),
  .quality_i(quality_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .level_pct_o(level_pct_o),
  .primary_o(primary_o), .primary_status_o(primary_status_o), .irq_o(irq_o));
